// file: cop_clock_ctrl.sv
// Auxiliary clock output and sampling PLL pin override control.
// Assumes ser_ui_tick and ref_tick are one-cycle pulses from logic on clk;
// configuration pins and the timestamp input are asynchronous.
//
// Summary of operation
// - The enable bit turns the auxiliary output divider and buffer on at 1, off at 0, reset 0.
// - Mode codes 0, 1, 2 give 16, 32, 64 UI clocks and codes 4 to 7 are reserved.
// - Mode code 3 sends the resampled timestamp input to the auxiliary output.
// - Clock modes 0 to 2 are built from serializer UI ticks and nothing else.
// - A serializer re-initialisation briefly disrupts the auxiliary clock.
// - Override bit 7 leaves PLL control with the pins at 0 and takes it from the register at 1.
// - Under override, bits 5:4 pick reference output D: off, or reference over 1, 2, 4.
// - Under override, bits 3:2 pick reference output C: off, or reference over 1, 2, 4.
// - Without override both select fields are ignored and the two config pins decide.
// - Reference output D never runs unless reference output C runs.
// - Under override, bit 1 selects the single-ended reference clock instead of its pin.
// - Under override, bit 0 enables the PLL instead of the enable pin.
`timescale 1ns/10ps
`default_nettype none

module cop_clock_ctrl
  import cop_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Serial control port
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output var  logic       spi_sdo,
  output var  logic       spi_sdo_oe,
  // Serializer and reference timing
  input  wire logic       ser_ui_tick,
  input  wire logic       ser_reinit,
  input  wire logic       ref_tick,
  // Configuration pins
  input  wire logic       pll_enable_pin,
  input  wire logic       single_ended_ref_pin,
  input  wire logic       clock_config_pin0,
  input  wire logic       clock_config_pin1,
  input  wire logic       timestamp_in_pin,
  // Outputs
  output var  logic       aux_clock_out_pin,
  output var  logic       ref_output_c,
  output var  logic       ref_output_d,
  output var  logic       pll_enable,
  output var  logic       single_ended_ref_clock,
  output var  logic [7:0] vco_trim
);

  // Reference select to ticks per half period; used for C and D
  function automatic logic [5:0] ref_half(input logic [1:0] sel);
    logic [5:0] h;
    h = 6'h00;
    unique case (sel)
      COP_REF_OFF:  h = 6'h00;
      COP_REF_DIV1: h = COP_HALF_DIV1;
      COP_REF_DIV2: h = COP_HALF_DIV2;
      COP_REF_DIV4: h = COP_HALF_DIV4;
    endcase
    return h;
  endfunction

  cop_req_t   req;
  logic [7:0] aux_out_mode_sel;
  logic [7:0] pll_pin_override;
  logic [7:0] rd_data;
  logic [1:0] pen_s;
  logic [1:0] se_s;
  logic [1:0] cfg0_s;
  logic [1:0] cfg1_s;
  logic [1:0] ts_s;
  logic       aux_div_q;
  logic       c_div_q;
  logic       d_div_q;

  // Register access over the serial port
  cop_spi_slave u_spi (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .req        (req),
    .rd_data    (rd_data)
  );

  // Address decode; unmapped reads return zero, writes are dropped
  wire wr_aux  = req.wr && (req.addr == COP_AUX_CTRL_ADDR);
  wire wr_ovr  = req.wr && (req.addr == COP_PLL_OVR_ADDR);
  wire wr_trim = req.wr && (req.addr == COP_VCO_TRIM_ADDR);
  assign rd_data = (req.addr == COP_AUX_CTRL_ADDR) ? aux_out_mode_sel :
                   (req.addr == COP_PLL_OVR_ADDR)  ? pll_pin_override :
                   (req.addr == COP_VCO_TRIM_ADDR) ? vco_trim : 8'h00;

  // Reserved bits are stored as written; host keeps them zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_out_mode_sel <= COP_AUX_CTRL_RST;
      pll_pin_override <= COP_PLL_OVR_RST;
      vco_trim         <= COP_VCO_TRIM_RST;
    end else begin
      if (wr_aux) aux_out_mode_sel <= req.data;
      if (wr_ovr) pll_pin_override <= req.data;
      if (wr_trim) vco_trim <= req.data;
    end
  end

  // Pin synchronisers; first stage read only by the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pen_s  <= 2'h0;
      se_s   <= 2'h0;
      cfg0_s <= 2'h0;
      cfg1_s <= 2'h0;
      ts_s   <= 2'h0;
    end else begin
      pen_s  <= {pen_s[0], pll_enable_pin};
      se_s   <= {se_s[0], single_ended_ref_pin};
      cfg0_s <= {cfg0_s[0], clock_config_pin0};
      cfg1_s <= {cfg1_s[0], clock_config_pin1};
      ts_s   <= {ts_s[0], timestamp_in_pin};
    end
  end

  // Auxiliary output decode
  wire       aux_out_enable     = aux_out_mode_sel[COP_AUX_EN_BIT];
  wire [2:0] aux_out_mode_field = aux_out_mode_sel[COP_AUX_MODE_MSB:0];
  wire       aux_clk_mode       = aux_out_mode_field <= COP_MODE_UI64;
  wire       aux_ts_mode        = aux_out_mode_field == COP_MODE_TSTAMP;
  wire       aux_run            = aux_out_enable && aux_clk_mode;
  wire [5:0] aux_half           = (aux_out_mode_field == COP_MODE_UI16) ? COP_HALF_UI16 :
                                  (aux_out_mode_field == COP_MODE_UI32) ? COP_HALF_UI32 :
                                  COP_HALF_UI64;

  // Divider stops while disabled; a serializer restart resets its phase
  cop_tick_div u_aux_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (!aux_run || ser_reinit),
    .tick     (ser_ui_tick),
    .half_cnt (aux_half),
    .q        (aux_div_q)
  );

  // Reserved codes and disabled state give a quiet low output
  wire next_aux = !aux_out_enable ? 1'b0 :
                  aux_ts_mode     ? ts_s[1] :
                  aux_clk_mode    ? aux_div_q : 1'b0;

  // Override or pin mode selection of the PLL controls
  wire       pll_override_enable       = pll_pin_override[COP_OVR_EN_BIT];
  wire [1:0] ref_out_d_select          = pll_pin_override[COP_REFD_LSB +: 2];
  wire [1:0] ref_out_c_select          = pll_pin_override[COP_REFC_LSB +: 2];
  wire       single_ended_ref_override = pll_pin_override[COP_SE_OVR_BIT];
  wire       pll_enable_override       = pll_pin_override[COP_PLL_EN_BIT];

  // Pin mode: config pins give C directly, D follows C when pin1 is high
  wire [1:0] pin_c_sel = {cfg1_s[1], cfg0_s[1]};
  wire [1:0] pin_d_sel = cfg1_s[1] ? pin_c_sel : COP_REF_OFF;
  wire [1:0] c_sel     = pll_override_enable ? ref_out_c_select : pin_c_sel;
  wire [1:0] d_sel     = pll_override_enable ? ref_out_d_select : pin_d_sel;
  wire       c_run     = c_sel != COP_REF_OFF;
  wire       d_run     = c_run && (d_sel != COP_REF_OFF);

  wire next_pll_en = pll_override_enable ? pll_enable_override : pen_s[1];
  wire next_se_sel = pll_override_enable ? single_ended_ref_override : se_s[1];

  // Reference dividers for outputs C and D
  cop_tick_div u_c_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (!c_run),
    .tick     (ref_tick),
    .half_cnt (ref_half(c_sel)),
    .q        (c_div_q)
  );

  cop_tick_div u_d_div (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clear    (!d_run),
    .tick     (ref_tick),
    .half_cnt (ref_half(d_sel)),
    .q        (d_div_q)
  );

  // Output flops; a selection change shows one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_clock_out_pin      <= 1'b0;
      ref_output_c           <= 1'b0;
      ref_output_d           <= 1'b0;
      pll_enable             <= 1'b0;
      single_ended_ref_clock <= 1'b0;
    end else begin
      aux_clock_out_pin      <= next_aux;
      ref_output_c           <= c_run && c_div_q;
      ref_output_d           <= d_run && d_div_q;
      pll_enable             <= next_pll_en;
      single_ended_ref_clock <= next_se_sel;
    end
  end

  // Checks
  a_aux_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    !aux_out_enable |=> !aux_clock_out_pin)
    else $error("aux output moved while disabled");

  a_reserved_low: assert property (@(posedge clk) disable iff (sys_rst)
    (aux_out_mode_field[2]) |=> !aux_clock_out_pin)
    else $error("aux output moved in reserved mode");

  a_ts_resample: assert property (@(posedge clk) disable iff (sys_rst)
    (aux_out_enable && aux_ts_mode) |=> aux_clock_out_pin == $past(ts_s[1]))
    else $error("timestamp not resampled to aux output");

  a_reinit_clear: assert property (@(posedge clk) disable iff (sys_rst)
    ser_reinit |=> !aux_div_q ##1 (aux_clock_out_pin == 1'b0 || !aux_clk_mode))
    else $error("serializer restart did not reset aux divider");

  a_no_tick_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (aux_run && !ser_ui_tick && !ser_reinit && $stable(aux_out_mode_sel)) |=>
      $stable(aux_div_q))
    else $error("aux clock moved without a UI tick");

  a_pll_en_src: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> pll_enable == ($past(pll_override_enable) ?
                            $past(pll_enable_override) : $past(pen_s[1])))
    else $error("PLL enable from wrong source");

  a_se_src: assert property (@(posedge clk) disable iff (sys_rst)
    pll_override_enable |=> single_ended_ref_clock == $past(single_ended_ref_override))
    else $error("single-ended select ignored override");

  a_d_needs_c: assert property (@(posedge clk) disable iff (sys_rst)
    ref_output_d |-> $past(c_run))
    else $error("output D ran without output C");

  a_c_off_low: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_override_enable && ref_out_c_select == COP_REF_OFF) |=> !ref_output_c)
    else $error("output C ran while deselected");

  a_d_sel_used: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_override_enable && ref_out_d_select == COP_REF_OFF) |=> !ref_output_d)
    else $error("output D ran while deselected");

  a_pin_mode_c: assert property (@(posedge clk) disable iff (sys_rst)
    (!pll_override_enable && pin_c_sel == COP_REF_OFF) |=> !ref_output_c)
    else $error("output C ran in pin mode while pins select off");

  a_pll_en_ovr: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_override_enable && pll_enable_override) |=> pll_enable)
    else $error("override did not enable PLL");

  a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_aux |=> aux_out_mode_sel == $past(req.data))
    else $error("control write not stored");

  a_aux_clk_path: assert property (@(posedge clk) disable iff (sys_rst)
    (aux_out_enable && aux_clk_mode) |=> aux_clock_out_pin == $past(aux_div_q))
    else $error("aux clock not taken from UI divider");

  a_aux_off_div: assert property (@(posedge clk) disable iff (sys_rst)
    !aux_out_enable |=> !aux_div_q)
    else $error("aux divider ran while disabled");

  a_rsvd_div_park: assert property (@(posedge clk) disable iff (sys_rst)
    aux_out_mode_field[2] |=> !aux_div_q)
    else $error("aux divider ran in reserved mode");

  a_ts_no_div: assert property (@(posedge clk) disable iff (sys_rst)
    aux_ts_mode |=> !aux_div_q)
    else $error("aux divider ran in timestamp mode");

  a_c_follow_div: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_override_enable && c_run) |=> ref_output_c == $past(c_div_q))
    else $error("output C not taken from its divider");

  a_d_follow_div: assert property (@(posedge clk) disable iff (sys_rst)
    (pll_override_enable && d_run) |=> ref_output_d == $past(d_div_q))
    else $error("output D not taken from its divider");

  a_d_off_no_c: assert property (@(posedge clk) disable iff (sys_rst)
    !c_run |=> !ref_output_d)
    else $error("output D ran while output C was off");

  a_pin_mode_d: assert property (@(posedge clk) disable iff (sys_rst)
    (!pll_override_enable && !cfg1_s[1]) |=> !ref_output_d)
    else $error("output D ran in pin mode while pins select off");

  a_se_pin_src: assert property (@(posedge clk) disable iff (sys_rst)
    !pll_override_enable |=> single_ended_ref_clock == $past(se_s[1]))
    else $error("single-ended select not taken from pin");

  a_c_div1_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    (c_run && c_sel == COP_REF_DIV1 && ref_tick) |=> c_div_q != $past(c_div_q))
    else $error("output C divider missed a reference tick");

endmodule
`default_nettype wire

// file: cop_clock_ctrl_tb.sv
// Self-checking bench for the auxiliary clock output and PLL override block.
// Assumes cop_pkg and cop_clock_ctrl are compiled first; one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module cop_clock_ctrl_tb;
  import cop_pkg::*;

  logic        clk, sys_rst, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
  logic        ser_reinit, timestamp_in_pin;
  logic        ser_ui_tick = 1'b0;
  logic        ref_tick    = 1'b0;
  logic        pll_enable_pin, single_ended_ref_pin, clock_config_pin0, clock_config_pin1;
  logic        aux_clock_out_pin, ref_output_c, ref_output_d;
  logic        pll_enable, single_ended_ref_clock;
  logic [7:0]  vco_trim;
  logic [15:0] rnd;
  logic [7:0]  mdl [3];
  logic [7:0]  v;
  int          bad_count, check_count;
  int          phase = 0;

  cop_clock_ctrl dut_u (
    .clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .ser_ui_tick(ser_ui_tick), .ser_reinit(ser_reinit), .ref_tick(ref_tick),
    .pll_enable_pin(pll_enable_pin), .single_ended_ref_pin(single_ended_ref_pin),
    .clock_config_pin0(clock_config_pin0), .clock_config_pin1(clock_config_pin1),
    .timestamp_in_pin(timestamp_in_pin), .aux_clock_out_pin(aux_clock_out_pin),
    .ref_output_c(ref_output_c), .ref_output_d(ref_output_d), .pll_enable(pll_enable),
    .single_ended_ref_clock(single_ended_ref_clock), .vco_trim(vco_trim));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Tick pulses: UI every 2 clocks, reference every 3, so counts stay distinct
  always @(posedge clk) begin
    phase       <= phase + 1;
    ser_ui_tick <= (phase % 2 == 0);
    ref_tick    <= (phase % 3 == 0);
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Ticks per half period for a reference select code; 0 means static
  function automatic int hsel(input logic [1:0] c);
    return (c == 2'h0) ? 0 : (c == 2'h1) ? 1 : (c == 2'h2) ? 2 : 4;
  endfunction

  function automatic logic pick(input int w);
    return (w == 0) ? aux_clock_out_pin : (w == 1) ? ref_output_c : ref_output_d;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One 24-bit frame; sclk half period of 6 clocks keeps within clk/8
  task automatic spi_xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                          output logic [7:0] q);
    logic [23:0] frame;
    frame = {rd, a, wd};
    q = 8'h00;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      spi_sclk <= 1'b0;
      spi_sdi  <= frame[i];
      repeat (6) @(posedge clk);
      if (rd && i < 8) begin
        q[i] = spi_sdo;
        check("sdo_oe", {15'h0000, spi_sdo_oe}, 16'h0001);
      end
      spi_sclk <= 1'b1;
      repeat (6) @(posedge clk);
    end
    spi_sclk <= 1'b0;
    spi_cs_n <= 1'b1;
    spi_sdi  <= ~spi_sdi; // Released line shows no stale bit
    repeat (8) @(posedge clk);
  endtask

  // Reserved bits are always written as zero by the callers
  task automatic reg_wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi_xfer(1'b0, a, d, q);
    if (a >= COP_AUX_CTRL_ADDR && a <= COP_VCO_TRIM_ADDR) mdl[a - COP_AUX_CTRL_ADDR] = d;
  endtask

  task automatic reg_rd(input logic [14:0] a);
    logic [7:0] q;
    logic [7:0] e;
    e = (a >= COP_AUX_CTRL_ADDR && a <= COP_VCO_TRIM_ADDR) ? mdl[a - COP_AUX_CTRL_ADDR] : 8'h00;
    spi_xfer(1'b1, a, 8'h00, q);
    check("reg_read", {8'h00, q}, {8'h00, e});
    check("sdo_oe_idle", {15'h0000, spi_sdo_oe}, 16'h0000);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  // Ticks between output edges; first interval skipped as it may be partial
  task automatic measure(input int w, input int half, input string nm);
    int   edges;
    int   cnt;
    logic prev;
    logic cur;
    edges = 0;
    cnt = 0;
    @(negedge clk);
    prev = pick(w);
    cur = prev;
    for (int n = 0; n < 300 && edges < 3; n++) begin
      @(negedge clk);
      cur = pick(w);
      if ((w == 0) ? ser_ui_tick : ref_tick) cnt++;
      if (cur !== prev) begin
        edges++;
        if (edges > 1) check(nm, 16'(cnt), 16'(half));
        cnt = 0;
      end
      prev = cur;
    end
    if (half == 0) begin
      check(nm, {15'h0000, cur}, 16'h0000);
      check(nm, 16'(edges), 16'h0000);
    end else begin
      check(nm, 16'(edges), 16'h0003);
    end
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk); // About twice the expected run length
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {sys_rst, spi_cs_n} = 2'h3;
    {spi_sclk, spi_sdi, ser_reinit, timestamp_in_pin} = 4'h0;
    {bad_count, check_count} = '0;
    {pll_enable_pin, single_ended_ref_pin, clock_config_pin0, clock_config_pin1} = 4'h0;
    rnd = 16'h98e1;
    mdl = '{8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    check("aux_rst", {15'h0000, aux_clock_out_pin}, 16'h0000);
    reg_rd(COP_AUX_CTRL_ADDR);
    reg_rd(COP_PLL_OVR_ADDR);
    reg_rd(COP_VCO_TRIM_ADDR);
    // Trim storage and an unmapped address
    rnd = lfsr_next(rnd);
    reg_wr(COP_VCO_TRIM_ADDR, {1'b0, rnd[6:0]});
    check("vco_trim", {8'h00, vco_trim}, {8'h00, 1'b0, rnd[6:0]});
    reg_wr(15'h005a, 8'h5a);
    reg_rd(15'h005a);
    reg_rd(COP_VCO_TRIM_ADDR);
    // Divided clock modes, changed only while disabled
    for (int m = 0; m < 3; m++) begin
      reg_wr(COP_AUX_CTRL_ADDR, 8'(m));
      reg_wr(COP_AUX_CTRL_ADDR, 8'h80 | 8'(m));
      measure(0, 8 << m, "aux_half");
      if (m == 0) begin
        @(posedge clk);
        ser_reinit <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("aux_reinit", {15'h0000, aux_clock_out_pin}, 16'h0000);
        @(posedge clk);
        ser_reinit <= 1'b0;
        measure(0, 8, "aux_resume");
      end
      reg_wr(COP_AUX_CTRL_ADDR, 8'(m));
      measure(0, 0, "aux_off");
    end
    // Resampled timestamp mode
    reg_wr(COP_AUX_CTRL_ADDR, 8'h03);
    reg_wr(COP_AUX_CTRL_ADDR, 8'h83);
    reg_rd(COP_AUX_CTRL_ADDR);
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr_next(rnd);
      @(posedge clk);
      timestamp_in_pin <= rnd[0];
      settle();
      check("aux_tstamp", {15'h0000, aux_clock_out_pin}, {15'h0000, rnd[0]});
    end
    reg_wr(COP_AUX_CTRL_ADDR, 8'h03);
    // Reserved codes leave the output static
    for (int m = 4; m < 8; m++) begin
      reg_wr(COP_AUX_CTRL_ADDR, 8'(m));
      reg_wr(COP_AUX_CTRL_ADDR, 8'h80 | 8'(m));
      measure(0, 0, "aux_rsvd");
      reg_wr(COP_AUX_CTRL_ADDR, 8'(m));
    end
    // Pin mode: register fields written but ignored
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr_next(rnd);
      reg_wr(COP_PLL_OVR_ADDR, {2'h0, rnd[9:4]});
      @(posedge clk);
      {clock_config_pin1, clock_config_pin0, single_ended_ref_pin, pll_enable_pin} <= rnd[3:0];
      settle();
      check("pll_en_pin", {15'h0000, pll_enable}, {15'h0000, rnd[0]});
      check("se_pin", {15'h0000, single_ended_ref_clock}, {15'h0000, rnd[1]});
      measure(1, hsel(rnd[3:2]), "ref_c_pin");
      measure(2, rnd[3] ? hsel(rnd[3:2]) : 0, "ref_d_pin");
    end
    // Override mode: every C and D select, enable and single-ended pins set opposite
    for (int c = 0; c < 4; c++) begin
      for (int d = 0; d < 4; d++) begin
        rnd = lfsr_next(rnd);
        v = {2'h2, 2'(d), 2'(c), rnd[1:0]};
        reg_wr(COP_PLL_OVR_ADDR, v);
        @(posedge clk);
        {single_ended_ref_pin, pll_enable_pin} <= ~rnd[1:0];
        settle();
        check("pll_en_ovr", {15'h0000, pll_enable}, {15'h0000, v[0]});
        check("se_ovr", {15'h0000, single_ended_ref_clock}, {15'h0000, v[1]});
        measure(1, hsel(2'(c)), "ref_c_ovr");
        measure(2, (c == 0) ? 0 : hsel(2'(d)), "ref_d_ovr");
      end
    end
    reg_rd(COP_PLL_OVR_ADDR);
    // Second reset in mid-run returns to pin control
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    mdl = '{8'h00, 8'h00, 8'h00};
    settle();
    check("pll_en_rst", {15'h0000, pll_enable}, {15'h0000, pll_enable_pin});
    reg_rd(COP_PLL_OVR_ADDR);
    reg_rd(COP_AUX_CTRL_ADDR);
    stop_test();
  end

endmodule

`default_nettype wire

// file: cop_pkg.sv
// Package for the auxiliary clock output and PLL pin override block.
// Holds register offsets, field positions, reset values and divider counts.
package cop_pkg;

  // Register offsets on the serial control port
  localparam logic [14:0] COP_AUX_CTRL_ADDR  = 15'h0057;
  localparam logic [14:0] COP_PLL_OVR_ADDR   = 15'h0058;
  localparam logic [14:0] COP_VCO_TRIM_ADDR  = 15'h0059;

  // Reset values
  localparam logic [7:0]  COP_AUX_CTRL_RST   = 8'h00;
  localparam logic [7:0]  COP_PLL_OVR_RST    = 8'h00;
  localparam logic [7:0]  COP_VCO_TRIM_RST   = 8'h00;

  // Auxiliary control fields
  localparam int          COP_AUX_EN_BIT     = 7;
  localparam int          COP_AUX_MODE_MSB   = 2;

  // Auxiliary mode codes
  localparam logic [2:0]  COP_MODE_UI16      = 3'h0;
  localparam logic [2:0]  COP_MODE_UI32      = 3'h1;
  localparam logic [2:0]  COP_MODE_UI64      = 3'h2;
  localparam logic [2:0]  COP_MODE_TSTAMP    = 3'h3;

  // Ticks per half period of the auxiliary clock (one tick per UI)
  localparam logic [5:0]  COP_HALF_UI16      = 6'h08;
  localparam logic [5:0]  COP_HALF_UI32      = 6'h10;
  localparam logic [5:0]  COP_HALF_UI64      = 6'h20;

  // PLL override fields
  localparam int          COP_OVR_EN_BIT     = 7;
  localparam int          COP_REFD_LSB       = 4;
  localparam int          COP_REFC_LSB       = 2;
  localparam int          COP_SE_OVR_BIT     = 1;
  localparam int          COP_PLL_EN_BIT     = 0;

  // Reference output select codes and ticks per half period
  localparam logic [1:0]  COP_REF_OFF        = 2'h0;
  localparam logic [1:0]  COP_REF_DIV1       = 2'h1;
  localparam logic [1:0]  COP_REF_DIV2       = 2'h2;
  localparam logic [1:0]  COP_REF_DIV4       = 2'h3;
  localparam logic [5:0]  COP_HALF_DIV1      = 6'h01;
  localparam logic [5:0]  COP_HALF_DIV2      = 6'h02;
  localparam logic [5:0]  COP_HALF_DIV4      = 6'h04;

  // Serial frame: 1 read flag, 15 address bits, 8 data bits
  localparam logic [4:0]  COP_ADDR_BITS_END  = 5'h0f;
  localparam logic [4:0]  COP_FRAME_BITS_END = 5'h17;

  // Register access request from the serial port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [14:0] addr;
    logic [7:0]  data;
  } cop_req_t;

endpackage

// file: cop_spi_slave.sv
// Serial control port slave: read flag, 15-bit address, 8 data bits, MSB first.
// Assumes sclk at most clk/8; all port pins are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module cop_spi_slave
  import cop_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Serial pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output var  logic       spi_sdo,
  output var  logic       spi_sdo_oe,
  // Register side
  output var  cop_req_t   req,
  input  wire logic [7:0] rd_data
);

  logic [2:0]  sclk_s;
  logic [1:0]  cs_s;
  logic [1:0]  sdi_s;
  logic [4:0]  bit_cnt;
  logic [22:0] sh;
  logic [7:0]  rd_sh;
  logic        rd_phase;

  // Two-stage synchronisers; only stage two and later feed logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s <= 3'h0;
      cs_s   <= 2'h3;
      sdi_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      cs_s   <= {cs_s[0], spi_cs_n};
      sdi_s  <= {sdi_s[0], spi_sdi};
    end
  end

  wire        sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire        sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire        active    = ~cs_s[1];
  wire [15:0] head      = {sh[14:0], sdi_s[1]};
  wire [23:0] word      = {sh, sdi_s[1]};
  wire        at_addr   = sclk_rise && (bit_cnt == COP_ADDR_BITS_END);
  wire        at_end    = sclk_rise && (bit_cnt == COP_FRAME_BITS_END);

  // Shift in on rising edges; frame restarts whenever select drops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt <= 5'h00;
      sh      <= 23'h00_0000;
    end else if (!active) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      bit_cnt <= (bit_cnt == COP_FRAME_BITS_END) ? 5'h00 : bit_cnt + 5'h01;
      sh      <= word[22:0];
    end
  end

  // Requests: read after the address, write after the data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req <= '0;
    end else begin
      req.rd <= active && at_addr && head[15];
      req.wr <= active && at_end && !word[23];
      if (active && at_addr) begin
        req.addr <= head[14:0];
      end
      if (active && at_end) begin
        req.data <= word[7:0];
      end
    end
  end

  // Read data leaves on falling edges, MSB first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_sh      <= 8'h00;
      rd_phase   <= 1'b0;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (!active) begin
      rd_phase   <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (req.rd) begin
      rd_sh    <= rd_data;
      rd_phase <= 1'b1;
    end else if (rd_phase && sclk_fall) begin
      spi_sdo    <= rd_sh[7];
      spi_sdo_oe <= 1'b1;
      rd_sh      <= {rd_sh[6:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// file: cop_tick_div.sv
// Toggle divider counting input ticks; one output level per half period.
// Assumes tick comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module cop_tick_div
  import cop_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [5:0] half_cnt,
  // Divided level
  output var  logic       q
);

  logic [5:0] cnt;
  wire        wrap = tick && (cnt >= half_cnt - 6'h01); // Shorter period applies at once

  // Clear parks the output low so a stopped divider is static
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 6'h00;
      q   <= 1'b0;
    end else if (clear) begin
      cnt <= 6'h00;
      q   <= 1'b0;
    end else if (wrap) begin
      cnt <= 6'h00;
      q   <= ~q;
    end else if (tick) begin
      cnt <= cnt + 6'h01;
    end
  end

endmodule
`default_nettype wire
